// ---- lapc_calc.sv ----
// Per-sample current and power calculator
`timescale 1ns/1ns
`default_nettype none
module lapc_calc
  import lapc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  lapc_calc_if.calc cif
);
  wire logic signed [32:0] cur_prod = $signed(cif.shunt) * $signed({1'b0, cif.scale});
  wire logic [15:0] cur_mag = cif.cur[15] ? 16'(-cif.cur) : cif.cur;
  wire logic [31:0] pwr_prod = cur_mag * {1'b0, cif.rail[14:0]};
  wire logic [15:0] next_cur = cif.scale_loaded ? 16'(cur_prod >>> CUR_SHIFT) : RESULT_RST;
  wire logic [15:0] next_pwr = cif.scale_loaded ? 16'(pwr_prod / PWR_DIV) : RESULT_RST;

  // Current after each shunt sample, power after each rail sample on the held current
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cif.cur <= RESULT_RST;
      cif.pwr <= RESULT_RST;
      cif.cur_stb <= 1'b0;
      cif.pwr_stb <= 1'b0;
    end else begin
      cif.cur_stb <= cif.shunt_stb;
      cif.pwr_stb <= cif.rail_stb;
      if (cif.shunt_stb) begin
        cif.cur <= next_cur;
      end
      if (cif.rail_stb) begin
        cif.pwr <= next_pwr;
      end
    end
  end

  a_power_after_rail:
    assert property (@(posedge clk) disable iff (!rst_n)
      cif.rail_stb |=> cif.pwr_stb && (!cif.scale_loaded || cif.pwr == $past(next_pwr)))
    else $error("power not updated after rail sample");
endmodule
`default_nettype wire

// ---- lapc_calc_if.sv ----
// Carrier between the alarm core and the current and power calculator
`timescale 1ns/1ns
`default_nettype none
interface lapc_calc_if;
  logic shunt_stb;
  logic rail_stb;
  logic [15:0] shunt;
  logic [15:0] rail;
  logic [15:0] scale;
  logic scale_loaded;
  logic cur_stb;
  logic pwr_stb;
  logic [15:0] cur;
  logic [15:0] pwr;
  modport core (output shunt_stb, rail_stb, shunt, rail, scale, scale_loaded,
                input cur_stb, pwr_stb, cur, pwr);
  modport calc (input shunt_stb, rail_stb, shunt, rail, scale, scale_loaded,
                output cur_stb, pwr_stb, cur, pwr);
endinterface
`default_nettype wire

// ---- lapc_host.sv ----
// Behavioural host issuing register accesses on the link port
`timescale 1ns/1ns
`default_nettype none
module lapc_host (
  input wire logic lclk,
  input wire logic lnk_busy,
  input wire logic lnk_done,
  input wire logic [15:0] lnk_rdata,
  output var logic lnk_req,
  output var logic lnk_wr,
  output var logic [7:0] lnk_addr,
  output var logic [15:0] lnk_wdata
);
  initial begin
    lnk_req = 1'b0;
    lnk_wr = 1'b0;
    lnk_addr = 8'hff;
    lnk_wdata = 16'hffff;
  end

  // A lost answer leaves rdata unknown so that the caller's compare fails
  task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
                        output logic [15:0] rdata);
    rdata = 16'hxxxx;
    @(negedge lclk);
    while (lnk_busy !== 1'b0) @(negedge lclk);
    lnk_req = 1'b1;
    lnk_wr = wr;
    lnk_addr = addr;
    lnk_wdata = wdata;
    @(negedge lclk);
    lnk_req = 1'b0;
    repeat (40) begin
      @(posedge lclk);
      #1;
      if (lnk_done === 1'b1) begin
        rdata = lnk_rdata;
        break;
      end
    end
    // Released lines show the inverse, never a stale copy
    lnk_wr = ~wr;
    lnk_addr = ~addr;
    lnk_wdata = ~wdata;
  endtask
endmodule
`default_nettype wire

// ---- lapc_pkg.sv ----
// Register map, field layout and constants of the limit alarm and power calculator
package lapc_pkg;
  localparam logic [7:0] A_SETUP = 8'h00;
  localparam logic [7:0] A_SHUNT = 8'h01;
  localparam logic [7:0] A_RAIL = 8'h02;
  localparam logic [7:0] A_POWER = 8'h03;
  localparam logic [7:0] A_CURRENT = 8'h04;
  localparam logic [7:0] A_SCALE = 8'h05;
  localparam logic [7:0] A_FLAGCTL = 8'h06;
  localparam logic [7:0] A_LIMIT = 8'h07;

  localparam logic [15:0] SETUP_RST = 16'h4127;
  localparam logic [15:0] SCALE_RST = 16'h0000;
  localparam logic [15:0] FLAGCTL_RST = 16'h0000;
  localparam logic [15:0] LIMIT_RST = 16'h0000;
  localparam logic [15:0] RESULT_RST = 16'h0000;

  // Flag control fields
  localparam int B_SHUNT_OVER = 15;
  localparam int B_SHUNT_UNDER = 14;
  localparam int B_RAIL_OVER = 13;
  localparam int B_RAIL_UNDER = 12;
  localparam int B_POWER_OVER = 11;
  localparam int B_READY_OUT = 10;
  localparam int B_THR_FLAG = 4;
  localparam int B_DONE_FLAG = 3;
  localparam int B_POLARITY = 1;
  localparam int B_LATCH = 0;
  localparam logic [15:0] FLAGCTL_WMASK = 16'hfc03;

  // Setup fields
  localparam int AVG_LSB = 9;
  localparam logic [2:0] MODE_OFF_A = 3'h0;
  localparam logic [2:0] MODE_OFF_B = 3'h4;

  // Scaling: current = shunt * scale / 2048, power = current * rail / 20000
  localparam int CUR_SHIFT = 11;
  localparam logic [31:0] PWR_DIV = 32'd20000;

  typedef enum logic [1:0] {
    LNK_IDLE = 2'b01,
    LNK_WAIT = 2'b10
  } lapc_lnk_t;
endpackage

// ---- lapc_top.sv ----
// Limit alarm, result averaging and register file of the shunt and rail monitor
// Operation
// - One threshold register at 07h, compared against one of five functions.
// - Flag pin is open drain, asserted when the selected quantity crosses.
// - With several functions enabled, the highest bit position wins.
// - Ready flag sits at D3, threshold flag at D4; host reads both.
// - With ready output disabled, pin responds only to threshold crossings.
// - Shunt functions compare after every individual shunt sample.
// - Threshold flag D4 sets whenever the compared value crosses.
// - Pin active level follows the polarity bit D1.
// - Latched flag and pin hold until setup write or flag control read.
// - Rail functions compare after every rail sample and raise flag and pin.
// - Power function compares calculated power after every rail sample.
// - Comparisons use individual samples, not averaged outputs.
// - One power step equals 25 current steps.
// - Current is shunt times scale divided by 2048.
// - Power is current times rail divided by 20000.
// - Rail result weight is a fixed 1.25 mV per count.
// - Rail result MSB always reads zero.
// - Current and power stay zero until scale is written.
// - Ready flag sets at cycle end; clears on active setup write or status read.
// - Current after each shunt sample, power after each rail sample.
// - Samples accumulate; averages load into results after all samples.
`timescale 1ns/1ns
`default_nettype none
module lapc_top
  import lapc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic lclk,
  input wire logic lnk_req,
  input wire logic lnk_wr,
  input wire logic [7:0] lnk_addr,
  input wire logic [15:0] lnk_wdata,
  output logic lnk_busy,
  output logic lnk_done,
  output logic [15:0] lnk_rdata,
  input wire logic shunt_sample_stb,
  input wire logic [15:0] shunt_sample,
  input wire logic rail_sample_stb,
  input wire logic [15:0] rail_sample,
  input wire logic alert_i,
  output logic alert_o,
  output logic alert_oe
);
  function automatic logic [3:0] avg_shift(input logic [2:0] code);
    case (code)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'ha;
    endcase
  endfunction

  function automatic logic [25:0] sext(input logic [15:0] v);
    sext = {{10{v[15]}}, v};
  endfunction

  // Link domain: request capture and toggle handshake
  logic lrst_q1;
  logic lrst_q2;
  lapc_lnk_t lstate;
  logic req_tgl;
  logic ack_q1;
  logic ack_q2;
  logic ack_q3;
  logic hold_wr;
  logic [7:0] hold_addr;
  logic [15:0] hold_wdata;
  logic ack_tgl;
  logic [15:0] core_rdata;

  // Reset reaches the link side through its own synchroniser
  always_ff @(posedge lclk) begin
    lrst_q1 <= rst_n;
    lrst_q2 <= lrst_q1;
  end

  wire logic lnk_ack = ack_q2 ^ ack_q3;
  wire logic lnk_take = lnk_req && (lstate == LNK_IDLE);
  assign lnk_busy = (lstate == LNK_WAIT);

  always_ff @(posedge lclk) begin
    if (!lrst_q2) begin
      lstate <= LNK_IDLE;
      req_tgl <= 1'b0;
      ack_q1 <= 1'b0;
      ack_q2 <= 1'b0;
      ack_q3 <= 1'b0;
      hold_wr <= 1'b0;
      hold_addr <= 8'h00;
      hold_wdata <= 16'h0000;
      lnk_done <= 1'b0;
      lnk_rdata <= 16'h0000;
    end else begin
      ack_q1 <= ack_tgl;
      ack_q2 <= ack_q1;
      ack_q3 <= ack_q2;
      lnk_done <= 1'b0;
      case (lstate)
        LNK_IDLE: begin
          if (lnk_take) begin
            hold_wr <= lnk_wr;
            hold_addr <= lnk_addr;
            hold_wdata <= lnk_wdata;
            req_tgl <= ~req_tgl;
            lstate <= LNK_WAIT;
          end
        end
        LNK_WAIT: begin
          if (lnk_ack) begin
            // Core read data stands still until the next request toggles
            lnk_rdata <= core_rdata;
            lnk_done <= 1'b1;
            lstate <= LNK_IDLE;
          end
        end
        default: lstate <= LNK_IDLE;
      endcase
    end
  end

  // Core domain
  logic req_q1;
  logic req_q2;
  logic req_q3;
  logic [15:0] setup;
  logic [15:0] scale;
  logic scale_loaded;
  logic [15:0] flagctl;
  logic [15:0] limit;
  logic thr_flag;
  logic done_flag;
  logic [15:0] shunt_res;
  logic [15:0] rail_res;
  logic [15:0] cur_res;
  logic [15:0] pwr_res;
  logic [25:0] shunt_sum;
  logic [25:0] rail_sum;
  logic [25:0] cur_sum;
  logic [25:0] pwr_sum;
  logic [10:0] smp_cnt;

  wire logic acc_go = req_q2 ^ req_q3;
  wire logic do_wr = acc_go && hold_wr;
  wire logic do_rd = acc_go && !hold_wr;
  wire logic setup_wr = do_wr && (hold_addr == A_SETUP);
  wire logic flag_rd = do_rd && (hold_addr == A_FLAGCTL);
  wire logic [2:0] wr_mode = hold_wdata[2:0];
  wire logic mode_off = (wr_mode == MODE_OFF_A) || (wr_mode == MODE_OFF_B);

  // Highest enabled function wins
  wire logic sel_so = flagctl[B_SHUNT_OVER];
  wire logic sel_su = flagctl[B_SHUNT_UNDER] && !sel_so;
  wire logic sel_ro = flagctl[B_RAIL_OVER] && !flagctl[B_SHUNT_UNDER] && !sel_so;
  wire logic sel_ru = flagctl[B_RAIL_UNDER] && !(|flagctl[B_SHUNT_OVER:B_RAIL_OVER]);
  wire logic sel_po = flagctl[B_POWER_OVER] && !(|flagctl[B_SHUNT_OVER:B_RAIL_UNDER]);
  wire logic latch_on = flagctl[B_LATCH];
  wire logic ready_out = flagctl[B_READY_OUT];
  wire logic polarity = flagctl[B_POLARITY];

  lapc_calc_if cif();
  assign cif.shunt_stb = shunt_sample_stb;
  assign cif.rail_stb = rail_sample_stb;
  assign cif.shunt = shunt_sample;
  assign cif.rail = rail_sample;
  assign cif.scale = scale;
  assign cif.scale_loaded = scale_loaded;

  lapc_calc u_calc (
    .clk(clk),
    .rst_n(rst_n),
    .cif(cif)
  );

  // Each raw sample is compared, never the averaged result
  wire logic signed [15:0] lim_s = $signed(limit);
  wire logic sh_over = $signed(shunt_sample) > lim_s;
  wire logic sh_under = $signed(shunt_sample) < lim_s;
  wire logic [15:0] rail_pos = {1'b0, rail_sample[14:0]};
  wire logic evt_sh = shunt_sample_stb && (sel_so || sel_su);
  wire logic evt_rl = rail_sample_stb && (sel_ro || sel_ru);
  wire logic evt_pw = cif.pwr_stb && sel_po;
  wire logic hit_sh = evt_sh && ((sel_so && sh_over) || (sel_su && sh_under));
  wire logic hit_rl = evt_rl && ((sel_ro && rail_pos > limit) || (sel_ru && rail_pos < limit));
  wire logic hit_pw = evt_pw && (cif.pwr > limit);
  wire logic cmp_evt = evt_sh || evt_rl || evt_pw;
  wire logic cmp_hit = hit_sh || hit_rl || hit_pw;
  wire logic flag_clr = setup_wr || flag_rd;

  // Latched: set wins over clear; unlatched: follows each comparison
  wire logic next_thr = latch_on ? (cmp_hit || (thr_flag && !flag_clr))
                               : (cmp_evt ? cmp_hit : (thr_flag && !flag_clr));

  // Averaging, counted per completed rail and power sample
  wire logic [3:0] shift = avg_shift(setup[AVG_LSB +: 3]);
  wire logic [10:0] smp_tgt = 11'(11'h001 << shift);
  wire logic cycle_end = cif.pwr_stb && (11'(smp_cnt + 11'h001) == smp_tgt);
  wire logic [25:0] sh_tot = shunt_sum + (shunt_sample_stb ? sext(shunt_sample) : 26'h0);
  wire logic [25:0] rl_tot = rail_sum + (rail_sample_stb ? {10'h000, rail_pos} : 26'h0);
  wire logic [25:0] cu_tot = cur_sum + (cif.cur_stb ? sext(cif.cur) : 26'h0);
  wire logic [25:0] pw_tot = pwr_sum + {10'h000, cif.pwr};
  wire logic [25:0] sh_avg = $signed(sh_tot) >>> shift;
  wire logic [25:0] cu_avg = $signed(cu_tot) >>> shift;
  wire logic [25:0] rl_avg = rl_tot >> shift;
  wire logic [25:0] pw_avg = pw_tot >> shift;
  wire logic next_done = cycle_end || (done_flag && !(setup_wr && !mode_off) && !flag_rd);

  wire logic [15:0] flag_view = {flagctl[15:5], thr_flag, done_flag, flagctl[2:0]};
  wire logic alert_act = thr_flag || (ready_out && done_flag);

  wire logic [15:0] rd_mux =
    (hold_addr == A_SETUP) ? setup :
    (hold_addr == A_SHUNT) ? shunt_res :
    (hold_addr == A_RAIL) ? rail_res :
    (hold_addr == A_POWER) ? pwr_res :
    (hold_addr == A_CURRENT) ? cur_res :
    (hold_addr == A_SCALE) ? scale :
    (hold_addr == A_FLAGCTL) ? flag_view :
    (hold_addr == A_LIMIT) ? limit : 16'h0000;

  // Held request fields are stable once the toggle is seen two stages late
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_q1 <= 1'b0;
      req_q2 <= 1'b0;
      req_q3 <= 1'b0;
      ack_tgl <= 1'b0;
      core_rdata <= 16'h0000;
    end else begin
      req_q1 <= req_tgl;
      req_q2 <= req_q1;
      req_q3 <= req_q2;
      if (acc_go) begin
        core_rdata <= rd_mux;
        ack_tgl <= ~ack_tgl;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      setup <= SETUP_RST;
      scale <= SCALE_RST;
      scale_loaded <= 1'b0;
      flagctl <= FLAGCTL_RST;
      limit <= LIMIT_RST;
    end else if (do_wr) begin
      case (hold_addr)
        A_SETUP: setup <= hold_wdata;
        A_SCALE: begin
          scale <= hold_wdata;
          scale_loaded <= 1'b1;
        end
        A_FLAGCTL: flagctl <= hold_wdata & FLAGCTL_WMASK;
        A_LIMIT: limit <= hold_wdata;
        default: scale_loaded <= scale_loaded;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      thr_flag <= 1'b0;
      done_flag <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      thr_flag <= next_thr;
      done_flag <= next_done;
      // Open drain: pulls low while inactive under high polarity
      alert_oe <= polarity ^ alert_act;
    end
  end
  assign alert_o = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shunt_sum <= 26'h0;
      rail_sum <= 26'h0;
      cur_sum <= 26'h0;
      pwr_sum <= 26'h0;
      smp_cnt <= 11'h000;
      shunt_res <= RESULT_RST;
      rail_res <= RESULT_RST;
      cur_res <= RESULT_RST;
      pwr_res <= RESULT_RST;
    end else if (cycle_end) begin
      shunt_sum <= 26'h0;
      rail_sum <= 26'h0;
      cur_sum <= 26'h0;
      pwr_sum <= 26'h0;
      smp_cnt <= 11'h000;
      shunt_res <= sh_avg[15:0];
      rail_res <= {1'b0, rl_avg[14:0]};
      cur_res <= cu_avg[15:0];
      pwr_res <= pw_avg[15:0];
    end else begin
      shunt_sum <= sh_tot;
      rail_sum <= rl_tot;
      cur_sum <= cu_tot;
      if (cif.pwr_stb) begin
        pwr_sum <= pw_tot;
        smp_cnt <= 11'(smp_cnt + 11'h001);
      end
    end
  end

  a_rail_msb_zero:
    assert property (@(posedge clk) disable iff (!rst_n) !rail_res[15])
    else $error("rail result msb set");
  a_unscaled_zero:
    assert property (@(posedge clk) disable iff (!rst_n)
      !scale_loaded |-> (cur_res == 16'h0000) && (pwr_res == 16'h0000))
    else $error("current or power nonzero before scale write");
  a_latch_hold:
    assert property (@(posedge clk) disable iff (!rst_n)
      thr_flag && latch_on && !flag_clr |=> thr_flag)
    else $error("latched threshold flag dropped");
  a_pin_polarity:
    assert property (@(posedge clk) disable iff (!rst_n)
      ##1 alert_oe == ($past(polarity) ^ $past(alert_act)))
    else $error("pin drive does not match polarity");
  a_ready_masked:
    assert property (@(posedge clk) disable iff (!rst_n) !ready_out |-> alert_act == thr_flag)
    else $error("pin responds to ready while disabled");
  a_shunt_over_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      shunt_sample_stb && sel_so && sh_over |=> thr_flag)
    else $error("shunt over crossing missed");
  a_done_sets:
    assert property (@(posedge clk) disable iff (!rst_n) cycle_end |=> done_flag)
    else $error("ready flag not set at cycle end");
  a_priority_pick:
    assert property (@(posedge clk) disable iff (!rst_n)
      flagctl[B_SHUNT_OVER] |-> !(sel_su || sel_ro || sel_ru || sel_po))
    else $error("lower priority function selected");
  a_unlatched_follow:
    assert property (@(posedge clk) disable iff (!rst_n)
      !latch_on && cmp_evt |=> thr_flag == $past(cmp_hit))
    else $error("unlatched flag did not follow comparison");
  a_link_ack:
    assert property (@(posedge lclk) disable iff (!lrst_q2)
      lnk_ack && lstate == LNK_WAIT |=> lnk_done && !lnk_busy)
    else $error("link access not completed");
endmodule
`default_nettype wire

// ---- tb_limit_alarm_and_power_calc.sv ----
// Self-checking bench of the limit alarm and power calculator
`timescale 1ns/1ns
`default_nettype none
module tb_limit_alarm_and_power_calc import lapc_pkg::*; ();
  typedef struct {
    logic [15:0] ctl;
    logic [15:0] lim;
    logic [15:0] sh;
    logic [15:0] rl;
    logic flag;
  } lapc_row_t;

  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic shunt_stb = 1'b0;
  logic rail_stb = 1'b0;
  logic [15:0] shunt_val = 16'h0000;
  logic [15:0] rail_val = 16'h0000;
  logic lnk_req;
  logic lnk_wr;
  logic lnk_busy;
  logic lnk_done;
  logic alert_o;
  logic alert_oe;
  logic [7:0] lnk_addr;
  logic [15:0] lnk_wdata;
  logic [15:0] lnk_rdata;
  wire logic alert_pin;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Rows: flag control, limit, shunt, rail, expected threshold flag
  lapc_row_t rows [10] = '{
    '{16'h8000, 16'h0064, 16'h0065, 16'h0000, 1'b1},
    '{16'h8002, 16'h0064, 16'h0064, 16'h0000, 1'b0},
    '{16'h4000, 16'hfff0, 16'hffef, 16'h0000, 1'b1},
    '{16'h2002, 16'h07d0, 16'h0000, 16'h07d1, 1'b1},
    '{16'h1000, 16'h07d0, 16'h0000, 16'h07d0, 1'b0},
    '{16'h0800, 16'h12b7, 16'h1f40, 16'h2570, 1'b1},
    '{16'h0802, 16'h12b8, 16'h1f40, 16'h2570, 1'b0},
    '{16'hc000, 16'h0064, 16'h0032, 16'h0000, 1'b0},
    '{16'h1000, 16'h07d0, 16'h0000, 16'h07cf, 1'b1},
    '{16'h6000, 16'h0064, 16'h0096, 16'h00c8, 1'b0}
  };

  // Pull-up on the open-drain pin
  assign alert_pin = alert_oe ? 1'b0 : 1'b1;

  initial forever #50 clk = ~clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end

  lapc_top lapc_top_inst (
    .clk(clk), .rst_n(rst_n), .lclk(lclk), .lnk_req(lnk_req), .lnk_wr(lnk_wr),
    .lnk_addr(lnk_addr), .lnk_wdata(lnk_wdata), .lnk_busy(lnk_busy), .lnk_done(lnk_done),
    .lnk_rdata(lnk_rdata), .shunt_sample_stb(shunt_stb), .shunt_sample(shunt_val),
    .rail_sample_stb(rail_stb), .rail_sample(rail_val), .alert_i(alert_pin),
    .alert_o(alert_o), .alert_oe(alert_oe)
  );

  lapc_host lapc_host_inst (
    .lclk(lclk), .lnk_busy(lnk_busy), .lnk_done(lnk_done), .lnk_rdata(lnk_rdata),
    .lnk_req(lnk_req), .lnk_wr(lnk_wr), .lnk_addr(lnk_addr), .lnk_wdata(lnk_wdata)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // A write that never completes would otherwise pass unnoticed
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    lapc_host_inst.access(1'b1, a, d, r);
    if ($isunknown(r)) begin
      n_mismatch++;
      $display("mismatch t=%0t write to %h not answered", $time, a);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] r;
    lapc_host_inst.access(1'b0, a, 16'h0000, r);
    chk(r, exp, what);
  endtask

  // Strobes stay three or more clocks apart; idle sample lines carry the inverse
  task automatic samp(input logic is_rail, input logic [15:0] v);
    @(negedge clk);
    shunt_stb = ~is_rail;
    rail_stb = is_rail;
    shunt_val = v;
    rail_val = v;
    @(negedge clk);
    shunt_stb = 1'b0;
    rail_stb = 1'b0;
    shunt_val = ~v;
    rail_val = ~v;
    repeat (3) @(negedge clk);
  endtask

  task automatic pair(input logic [15:0] s, input logic [15:0] r);
    samp(1'b0, s);
    samp(1'b1, r);
    repeat (3) @(negedge clk);
  endtask

  task automatic pin(input logic exp, input string what);
    chk({14'h0000, alert_o, alert_oe}, {15'h0000, exp}, what);
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [15:0] exp_ctl;
    repeat (10) @(negedge clk);
    chk({12'h000, alert_o, alert_oe, lnk_busy, lnk_done}, 16'h0000, "outputs in reset");
    chk(lnk_rdata, 16'h0000, "rdata in reset");
    rst_n = 1'b1;
    repeat (4) @(negedge lclk);
    for (int a = 0; a < 8; a++) begin
      rdc(8'(a), (a == 0) ? SETUP_RST : 16'h0000, "reset value");
    end
    wr(8'h08, 16'h1234);
    rdc(8'h08, 16'h0000, "unmapped index");
    wr(A_CURRENT, 16'hffff);
    rdc(A_CURRENT, 16'h0000, "read-only current");
    pair(16'h1f40, 16'ha570);
    rdc(A_CURRENT, 16'h0000, "current before scale");
    rdc(A_POWER, 16'h0000, "power before scale");
    rdc(A_SHUNT, 16'h1f40, "shunt result");
    rdc(A_RAIL, 16'h2570, "rail result msb");
    wr(A_SCALE, 16'h0a00);
    pair(16'h1f40, 16'ha570);
    rdc(A_CURRENT, 16'h2710, "current");
    rdc(A_POWER, 16'h12b8, "power");
    foreach (rows[i]) begin
      wr(A_FLAGCTL, rows[i].ctl);
      wr(A_LIMIT, rows[i].lim);
      pair(rows[i].sh, rows[i].rl);
      exp_ctl = (rows[i].ctl & FLAGCTL_WMASK) | 16'h0008 | {11'h000, rows[i].flag, 4'h0};
      pin(rows[i].flag ^ rows[i].ctl[B_POLARITY], "pin level");
      rdc(A_FLAGCTL, exp_ctl, "flag control");
    end
    wr(A_FLAGCTL, 16'h8001);
    wr(A_LIMIT, 16'h0064);
    pair(16'h00c8, 16'h0000);
    pair(16'h0032, 16'h0000);
    pin(1'b1, "latched pin held");
    rdc(A_FLAGCTL, 16'h8019, "latched flags");
    pin(1'b0, "latch cleared by read");
    pair(16'h00c8, 16'h0000);
    pin(1'b1, "latched again");
    wr(A_SETUP, SETUP_RST);
    pin(1'b0, "latch cleared by setup write");
    rdc(A_FLAGCTL, 16'h8001, "flags after setup write");
    wr(A_FLAGCTL, 16'h8000);
    pair(16'h00c8, 16'h0000);
    pin(1'b1, "unlatched set");
    pair(16'h0032, 16'h0000);
    pin(1'b0, "unlatched follows");
    wr(A_FLAGCTL, 16'h8400);
    pair(16'h0032, 16'h0000);
    pin(1'b1, "ready on pin");
    rdc(A_FLAGCTL, 16'h8408, "ready source");
    pin(1'b0, "ready cleared by read");
    // Four-sample average: a single sample above the limit still fires
    wr(A_SETUP, SETUP_RST | 16'h0200);
    wr(A_FLAGCTL, 16'h8000);
    wr(A_LIMIT, 16'h000f);
    pair(16'h0004, 16'h0000);
    pair(16'h0008, 16'h0000);
    pair(16'h000c, 16'h0000);
    rdc(A_SHUNT, 16'h0032, "result held mid-average");
    rdc(A_FLAGCTL, 16'h8000, "no ready mid-average");
    pair(16'h0010, 16'h0000);
    pin(1'b1, "sample above limit");
    rdc(A_SHUNT, 16'h000a, "averaged shunt");
    rdc(A_FLAGCTL, 16'h8018, "flag with average in range");
    // Power-down setup writes drop the threshold flag but keep the ready flag
    wr(A_SETUP, 16'h4120);
    pair(16'h0010, 16'h0000);
    wr(A_SETUP, 16'h4124);
    rdc(A_FLAGCTL, 16'h8008, "ready kept on power-down write");
    // Reset in mid-run brings back defaults and the unscaled zero results
    @(negedge clk);
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    chk({12'h000, alert_o, alert_oe, lnk_busy, lnk_done}, 16'h0000, "outputs in mid-run reset");
    chk(lnk_rdata, 16'h0000, "rdata in mid-run reset");
    rst_n = 1'b1;
    repeat (4) @(negedge lclk);
    rdc(A_FLAGCTL, FLAGCTL_RST, "flag control after reset");
    rdc(A_SETUP, SETUP_RST, "setup after reset");
    pair(16'h1f40, 16'ha570);
    rdc(A_CURRENT, 16'h0000, "current after reset");
    final_report();
  end
endmodule
`default_nettype wire
